/* rtl/astc_pkg.sv */
// Constants shared by the acquisition start trigger control block
package astc_pkg;
    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
    localparam logic [CNT_W-1:0] CNT_MAX = 24'hffffff;
    localparam logic [1:0] ORIGIN_SOFTWARE = 2'h0;
    localparam logic [1:0] ORIGIN_LINE1 = 2'h1;
    localparam logic [1:0] ORIGIN_LINE2 = 2'h2;
    localparam logic POLICY_SINGLE = 1'h0;
    localparam logic POLICY_CONTINUOUS = 1'h1;
    localparam logic SHUTTER_TIMED = 1'h0;
    localparam logic SHUTTER_WIDTH = 1'h1;
    localparam logic EDGE_RISING = 1'h0;
    localparam logic EDGE_FALLING = 1'h1;
    typedef enum logic [1:0] {
        ASTC_IDLE,
        ASTC_WAIT,
        ASTC_EXPOSE,
        ASTC_RECOVER
    } astc_state_t;
endpackage

/* rtl/astc_edge_det.sv */
// Selectable edge detector giving a one-cycle pulse per edge
`timescale 1ns/1ps
module astc_edge_det (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic sig_i,
    input wire logic falling_i,
    output logic pulse_o
);
    import astc_pkg::*;
    logic prev_q;
    logic prev_d;

    always_comb begin
        prev_d = sig_i;
        pulse_o = (falling_i == EDGE_FALLING) ? (prev_q & ~sig_i) : (~prev_q & sig_i);
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            // Pin level loaded so a line idling high gives no edge after reset
            prev_q <= sig_i;
        end else if (ce_i) begin
            prev_q <= prev_d;
        end
    end
endmodule

/* rtl/astc_trigger_ctrl.sv */
// Acquisition start trigger control: arming, gating, pacing and timed exposure
//
// How it works
// - With gating on and software origin, a frame starts only on a host fire command.
// - In the waiting status a software start trigger begins exposure.
// - Beginning exposure leaves the waiting status, so no further trigger is taken.
// - The waiting status returns by itself once a new trigger can be taken.
// - Software-started exposure length comes from the programmed shutter duration.
// - A software trigger arriving outside the waiting status is dropped.
// - A fire command counts as a start trigger while the target selects it.
// - With rate limiting off, gated frames follow their triggers and ungated internal starts follow the minimum frame period.
// - With rate limiting on, internal starts follow the programmed rate period.
// - The arm command readies the block to enter the waiting status.
// - With gating off and continuous policy, starts are made from arm until disarm.
// - A rate period shorter than the minimum frame period is raised to the minimum.
// - With gating on and a line origin, the chosen edge of that line is the start trigger.
`timescale 1ns/1ps
module astc_trigger_ctrl (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic trigger_target_choice_i,
    input wire logic external_start_gating_i,
    input wire logic [1:0] start_origin_choice_i,
    input wire logic edge_polarity_i,
    input wire logic [1:0] line_in_i,
    input wire logic shutter_duration_policy_i,
    input wire logic [astc_pkg::CNT_W-1:0] shutter_duration_value_i,
    input wire logic internal_rate_limit_on_i,
    input wire logic [astc_pkg::CNT_W-1:0] internal_rate_value_i,
    input wire logic [astc_pkg::CNT_W-1:0] min_frame_period_i,
    input wire logic capture_run_policy_i,
    input wire logic capture_arm_command_i,
    input wire logic capture_disarm_command_i,
    input wire logic host_fire_command_i,
    output logic armed_o,
    output logic waiting_o,
    output logic exposing_o,
    output logic start_pulse_o
);
    import astc_pkg::*;

    astc_state_t state_q, state_d;
    logic armed_q, armed_d;
    logic waiting_q, waiting_d;
    logic exposing_q, exposing_d;
    logic start_q, start_d;
    logic [CNT_W-1:0] exp_cnt_q, exp_cnt_d;
    logic [CNT_W-1:0] frame_cnt_q, frame_cnt_d;
    logic fire_pulse;
    logic line_sel;
    logic line_pulse;
    logic sw_trig;
    logic hw_trig;
    logic int_trig;
    logic trig;
    logic exp_last;
    logic [CNT_W-1:0] pace_period;

    astc_edge_det u_fire_edge (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .sig_i(host_fire_command_i),
        .falling_i(EDGE_RISING),
        .pulse_o(fire_pulse)
    );

    astc_edge_det u_line_edge (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .sig_i(line_sel),
        .falling_i(edge_polarity_i),
        .pulse_o(line_pulse)
    );

    always_comb begin
        line_sel = (start_origin_choice_i == ORIGIN_LINE2) ? line_in_i[1] : line_in_i[0];
        // Fire pulse routed only when the start trigger is the target
        sw_trig = fire_pulse & trigger_target_choice_i & external_start_gating_i
            & (start_origin_choice_i == ORIGIN_SOFTWARE);
        hw_trig = line_pulse & external_start_gating_i
            & ((start_origin_choice_i == ORIGIN_LINE1)
            | (start_origin_choice_i == ORIGIN_LINE2));
        // Enabled rate never faster than the minimum frame period
        pace_period = (internal_rate_limit_on_i && internal_rate_value_i > min_frame_period_i)
            ? internal_rate_value_i : min_frame_period_i;
        // Internal starts only while ungated; gated frames ignore pacing
        int_trig = ~external_start_gating_i & (frame_cnt_q >= pace_period);
        trig = sw_trig | hw_trig | int_trig;
        exp_last = (exp_cnt_q + CNT_ONE >= shutter_duration_value_i);
    end

    always_comb begin
        state_d = state_q;
        armed_d = armed_q;
        exp_cnt_d = exp_cnt_q;
        frame_cnt_d = (frame_cnt_q == CNT_MAX) ? frame_cnt_q : frame_cnt_q + CNT_ONE;
        start_d = 1'b0;
        if (capture_arm_command_i && !armed_q) begin
            armed_d = 1'b1;
            frame_cnt_d = CNT_MAX;
        end
        if (capture_disarm_command_i) begin
            armed_d = 1'b0;
        end
        case (state_q)
            ASTC_IDLE: begin
                if (armed_q) begin
                    state_d = ASTC_WAIT;
                end
            end
            ASTC_WAIT: begin
                if (!armed_q) begin
                    state_d = ASTC_IDLE;
                end else if (trig) begin
                    state_d = ASTC_EXPOSE;
                    start_d = 1'b1;
                    exp_cnt_d = CNT_ZERO;
                    frame_cnt_d = CNT_ZERO;
                    if (capture_run_policy_i == POLICY_SINGLE) begin
                        armed_d = 1'b0;
                    end
                end
            end
            ASTC_EXPOSE: begin
                // Software starts always timed; width policy not honoured here
                exp_cnt_d = exp_cnt_q + CNT_ONE;
                if (exp_last) begin
                    state_d = ASTC_RECOVER;
                end
            end
            ASTC_RECOVER: begin
                if (frame_cnt_q >= min_frame_period_i) begin
                    state_d = armed_q ? ASTC_WAIT : ASTC_IDLE;
                end
            end
            default: begin
                state_d = ASTC_IDLE;
            end
        endcase
        waiting_d = (state_d == ASTC_WAIT);
        exposing_d = (state_d == ASTC_EXPOSE);
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_q <= ASTC_IDLE;
            armed_q <= 1'b0;
            waiting_q <= 1'b0;
            exposing_q <= 1'b0;
            start_q <= 1'b0;
            exp_cnt_q <= CNT_ZERO;
            frame_cnt_q <= CNT_MAX;
        end else if (ce_i) begin
            state_q <= state_d;
            armed_q <= armed_d;
            waiting_q <= waiting_d;
            exposing_q <= exposing_d;
            start_q <= start_d;
            exp_cnt_q <= exp_cnt_d;
            frame_cnt_q <= frame_cnt_d;
        end
    end

    always_comb begin
        armed_o = armed_q;
        waiting_o = waiting_q;
        exposing_o = exposing_q;
        start_pulse_o = start_q;
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_accept_sw;
        ce_i && state_q == ASTC_WAIT && armed_q && sw_trig;
    endsequence

    sequence s_started;
        start_pulse_o && exposing_o && !waiting_o;
    endsequence

    AST_SW_START: assert property (s_accept_sw |=> s_started)
        else $error("software trigger in waiting status did not start exposure");
    AST_LEAVE_WAIT: assert property (s_accept_sw ##1 ce_i |-> !waiting_o)
        else $error("waiting status kept after a start");
    AST_DISCARD: assert property (ce_i && state_q != ASTC_WAIT && sw_trig
        |=> !start_pulse_o)
        else $error("software trigger outside waiting status started a frame");
    AST_GATED_ONLY_FIRE: assert property (ce_i && external_start_gating_i
        && (start_origin_choice_i == ORIGIN_SOFTWARE) && !fire_pulse
        |=> !start_pulse_o)
        else $error("gated software mode started without a fire command");
    AST_REWAIT: assert property (ce_i && state_q == ASTC_RECOVER && armed_q
        && !capture_disarm_command_i && frame_cnt_q >= min_frame_period_i
        |=> waiting_o)
        else $error("waiting status not restored after recovery");
    AST_EXPOSE_END: assert property (ce_i && state_q == ASTC_EXPOSE && exp_last
        |=> !exposing_o)
        else $error("exposure overran the programmed duration");
    AST_EXPOSE_HOLD: assert property (ce_i && state_q == ASTC_EXPOSE && !exp_last
        |=> exposing_o)
        else $error("exposure ended early");
    AST_FIRE_ONE: assert property (ce_i && fire_pulse |=> !fire_pulse)
        else $error("fire command produced more than one pulse");
    AST_PACE: assert property (ce_i && !external_start_gating_i && state_q == ASTC_WAIT
        && frame_cnt_q < pace_period |=> !start_pulse_o)
        else $error("internal start came before the pacing period");
    AST_FREE_RUN: assert property (ce_i && !external_start_gating_i && state_q == ASTC_WAIT
        && armed_q && frame_cnt_q >= pace_period |=> start_pulse_o)
        else $error("internal start missing in free-run");
    AST_MIN_RATE: assert property (pace_period >= min_frame_period_i)
        else $error("pacing period below the minimum frame period");
    AST_ARM: assert property (ce_i && state_q == ASTC_IDLE && !armed_q
        |=> !waiting_o)
        else $error("waiting status entered without passing through arm");
    AST_TARGET_OFF: assert property (ce_i && external_start_gating_i && !trigger_target_choice_i
        && (start_origin_choice_i == ORIGIN_SOFTWARE) |=> !start_pulse_o)
        else $error("frame started while the fire command did not target the start trigger");
    AST_LINE_START: assert property (ce_i && state_q == ASTC_WAIT && armed_q && hw_trig
        |=> start_pulse_o)
        else $error("chosen line edge in waiting status did not start a frame");
endmodule

/* bench/astc_host_model.sv */
// Host software model issuing commands to the trigger control block
`timescale 1ns/1ps
module astc_host_model (
    input wire logic clk_sys_i,
    input wire logic waiting_i,
    output logic arm_o,
    output logic disarm_o,
    output logic fire_o,
    output logic target_o,
    output logic shutter_policy_o
);
    import astc_pkg::*;
    initial begin
        arm_o = 1'b0;
        disarm_o = 1'b0;
        fire_o = 1'b0;
        target_o = 1'b1;
        shutter_policy_o = SHUTTER_TIMED;
    end
    // One-cycle command: 0 arm, 1 disarm, else fire
    task automatic pulse(input int which);
        @(posedge clk_sys_i);
        case (which)
            0: arm_o <= 1'b1;
            1: disarm_o <= 1'b1;
            default: fire_o <= 1'b1;
        endcase
        @(posedge clk_sys_i);
        arm_o <= 1'b0;
        disarm_o <= 1'b0;
        fire_o <= 1'b0;
    endtask
    // Fire level held or dropped at the next edge
    task automatic hold_fire(input logic v);
        @(posedge clk_sys_i);
        fire_o <= v;
    endtask
    // Called just after an edge
    task automatic set_target(input logic v);
        target_o <= v;
    endtask
    // Fire once the status shows ready, or after 300 cycles without it
    task automatic fire_paced();
        int k;
        k = 0;
        while (waiting_i !== 1'b1 && k < 300) begin
            @(posedge clk_sys_i);
            #1;
            k++;
        end
        pulse(2);
    endtask
endmodule

/* bench/tb.sv */
// Testbench for the acquisition start trigger control block
`timescale 1ns/1ps
module tb;
    import astc_pkg::*;
    typedef struct {
        logic [CNT_W-1:0] shut;
        logic [CNT_W-1:0] per;
        logic [CNT_W-1:0] len;
    } astc_row_t;
    astc_row_t rows[3] = '{'{24'h0, 24'h4, 24'h1}, '{24'h5, 24'h8, 24'h5},
        '{24'h3, 24'h14, 24'h3}};
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic gating = 1'b1;
    logic polarity = EDGE_RISING;
    logic rate_on = 1'b0;
    logic policy = POLICY_CONTINUOUS;
    logic [1:0] origin = ORIGIN_SOFTWARE;
    logic [1:0] line_in = 2'h0;
    logic [CNT_W-1:0] shutter = 24'h000004;
    logic [CNT_W-1:0] rate = 24'h000006;
    logic [CNT_W-1:0] min_per = 24'h00000c;
    logic armed, waiting, exposing, start, arm, disarm, fire, target, spol;
    int err_total = 0;
    int n_tests = 0;
    int starts = 0;
    int s0, n, p;
    astc_trigger_ctrl i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
        .trigger_target_choice_i(target), .external_start_gating_i(gating),
        .start_origin_choice_i(origin), .edge_polarity_i(polarity), .line_in_i(line_in),
        .shutter_duration_policy_i(spol), .shutter_duration_value_i(shutter),
        .internal_rate_limit_on_i(rate_on), .internal_rate_value_i(rate),
        .min_frame_period_i(min_per), .capture_run_policy_i(policy),
        .capture_arm_command_i(arm), .capture_disarm_command_i(disarm),
        .host_fire_command_i(fire), .armed_o(armed), .waiting_o(waiting),
        .exposing_o(exposing), .start_pulse_o(start));
    astc_host_model i_host (.clk_sys_i(clk_sys_i), .waiting_i(waiting), .arm_o(arm),
        .disarm_o(disarm), .fire_o(fire), .target_o(target), .shutter_policy_o(spol));
    always #2.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (start === 1'b1) starts++;
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_num(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wait_start(output int cnt);
        cnt = 0;
        do begin
            step(1);
            cnt++;
        end while (start !== 1'b1 && cnt < 300);
    endtask
    task automatic frame(input astc_row_t r);
        int q, m;
        @(posedge clk_sys_i);
        shutter <= r.shut;
        min_per <= r.per;
        i_host.fire_paced();
        #1;
        chk_bit(start, 1'b1);
        chk_bit(waiting, 1'b0);
        q = 0;
        m = 0;
        while (waiting !== 1'b1 && q < 300) begin
            if (exposing === 1'b1) m++;
            step(1);
            q++;
        end
        chk_num(m, r.len);
        chk_bit(q >= r.per - 2 && q <= r.per + 2, 1'b1);
    endtask
    task automatic test_done();
        if (err_total == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #50000;
        err_total++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1;
        chk_bit(armed | waiting | exposing | start, 1'b0);
        i_host.pulse(2);
        step(4);
        chk_num(starts, 0);
        i_host.pulse(0);
        #1;
        chk_bit(armed, 1'b1);
        step(1);
        chk_bit(waiting, 1'b1);
        step(30);
        chk_num(starts, 0);
        foreach (rows[i]) frame(rows[i]);
        s0 = starts;
        i_host.fire_paced();
        i_host.pulse(2);
        step(40);
        chk_num(starts - s0, 1);
        s0 = starts;
        i_host.hold_fire(1'b1);
        step(60);
        chk_num(starts - s0, 1);
        i_host.hold_fire(1'b0);
        i_host.set_target(1'b0);
        s0 = starts;
        i_host.pulse(2);
        step(10);
        chk_num(starts - s0, 0);
        for (int i = 0; i < 2; i++) begin
            s0 = starts;
            @(posedge clk_sys_i);
            i_host.set_target(1'b1);
            origin <= ORIGIN_LINE1;
            polarity <= i[0];
            step(30);
            @(posedge clk_sys_i);
            line_in[0] <= ~line_in[0];
            step(30);
            chk_num(starts - s0, 1);
        end
        // Fire command given while frozen is lost
        @(posedge clk_sys_i);
        origin <= ORIGIN_SOFTWARE;
        ce_i <= 1'b0;
        s0 = starts;
        i_host.pulse(2);
        step(3);
        chk_bit(waiting, 1'b1);
        @(posedge clk_sys_i);
        ce_i <= 1'b1;
        step(5);
        chk_num(starts - s0, 0);
        @(posedge clk_sys_i);
        gating <= 1'b0;
        rate_on <= 1'b1;
        min_per <= 24'h00000c;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys_i);
            rate <= (i == 0) ? 24'h000006 : 24'h00001e;
            p = (i == 0) ? 12 : 30;
            repeat (3) wait_start(n);
            chk_bit(n >= p && n <= p + 2, 1'b1);
        end
        i_host.pulse(1);
        step(5);
        s0 = starts;
        step(60);
        chk_num(starts - s0, 0);
        chk_bit(armed, 1'b0);
        // Single policy: one frame per arm, then back to idle
        @(posedge clk_sys_i);
        policy <= POLICY_SINGLE;
        gating <= 1'b1;
        i_host.pulse(0);
        i_host.fire_paced();
        #1;
        chk_bit(start, 1'b1);
        step(40);
        chk_bit(armed | waiting, 1'b0);
        test_done();
    end
endmodule
